// ### core/setpoint_supervisor_pkg.sv
`default_nettype none
package setpoint_supervisor_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned MS_TIME       = 1;
   localparam int unsigned MS_CYCLES     = CLK_HZ * MS_TIME / 1000;
   localparam int unsigned CLK_KHZ       = CLK_HZ / 1000;
   localparam int unsigned STRAP_SETTLE  = 4;
   localparam int unsigned RESTART_MS    = 10;
   localparam int unsigned PHASES        = 16;
   localparam int unsigned STRAP_LEVELS  = 28;
   localparam logic [3:0]  MAX_NUM       = 4'hb;
   localparam logic [19:0] MAX_DEN       = 20'h0000a;
   localparam logic [8:0]  PCT_FULL      = 9'h064;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SETPT  = 8'h04;
   localparam logic [7:0] ADDR_OVUV   = 8'h08;
   localparam logic [7:0] ADDR_PGTH   = 8'h0c;
   localparam logic [7:0] ADDR_PGDLY  = 8'h10;
   localparam logic [7:0] ADDR_FSW    = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   localparam logic [7:0] ADDR_LIMITS = 8'h1c;

   localparam int unsigned ST_PG_BIT   = 0;
   localparam int unsigned ST_OV_BIT   = 1;
   localparam int unsigned ST_UV_BIT   = 2;

   localparam logic [15:0] SHORT_MV  = 16'h0258;
   localparam logic [15:0] FLOAT_MV  = 16'h04b0;
   localparam logic [15:0] HIGH_MV   = 16'h09c4;
   localparam logic [15:0] STRAP_MV [STRAP_LEVELS] = '{
      16'h0258, 16'h028a, 16'h02bc, 16'h02ee, 16'h0320, 16'h0352, 16'h0384,
      16'h03b6, 16'h03e8, 16'h041a, 16'h044c, 16'h047e, 16'h04b0, 16'h04e2,
      16'h0514, 16'h0578, 16'h05dc, 16'h0640, 16'h06a4, 16'h0708, 16'h076c,
      16'h07d0, 16'h0834, 16'h0898, 16'h08fc, 16'h09c4, 16'h0bb8, 16'h0ce4};
   localparam logic [15:0] BIN_EDGE [5] = '{
      16'h03dc, 16'h0567, 16'h07b7, 16'h095e, 16'h0b93};
   localparam logic [15:0] BIN_CEIL [6] = '{
      16'h04b0, 16'h06a4, 16'h09c4, 16'h0b9a, 16'h0e60, 16'h122a};

   localparam logic [7:0]  OV_PCT_RST  = 8'h0f;
   localparam logic [7:0]  UV_PCT_RST  = 8'h0f;
   localparam logic [7:0]  PG_ON_RST   = 8'h5a;
   localparam logic [7:0]  PG_OFF_RST  = 8'h55;
   localparam logic [15:0] PG_DLY_RST  = 16'h000a;
   localparam logic [9:0]  FSW_RST     = 10'h140;
   localparam logic [9:0]  FSW_MIN     = 10'h0c8;
   localparam logic [9:0]  FSW_MAX     = 10'h280;
   localparam logic [3:0]  RETRY_RST   = 4'hf;
   localparam logic [3:0]  RETRY_INF   = 4'hf;

   typedef enum logic [1:0] {
      SYNC_INTERNAL, SYNC_INPUT, SYNC_OUTPUT, SYNC_RSVD
   } sync_mode_t;

   typedef enum logic [2:0] {
      S_INIT, S_OFF, S_RUN, S_FAULT, S_LOCK
   } state_t;

   typedef struct packed {
      logic [3:0]  retry;
      logic [3:0]  phase;
      logic        crowbar;
      sync_mode_t  sync_mode;
      logic        tune_en;
      logic        pg_tune;
      logic        pg_pp;
      logic        ovr_en;
      logic [15:0] cmd_mv;
      logic [7:0]  uv_pct;
      logic [7:0]  ov_pct;
      logic [7:0]  pg_off;
      logic [7:0]  pg_on;
      logic [15:0] pg_dly;
      logic [9:0]  fsw;
   } cfg_t;
endpackage : setpoint_supervisor_pkg
`default_nettype wire

// ### core/output_setpoint_supervisor.sv
// Function
// - resistor strap picks one of 28 setpoints
// - strap sampled once at start-up, latched
// - three-level strap: 0.60, 1.2, 2.5 V
// - host command replaces strapped setpoint
// - setpoint limited to 1.1 times nominal, to nominal with three-level strap
// - while enabled, cap by enable-time bin
// - disabled output: only strap maximum applies
// - over-voltage above nominal plus 15 percent
// - shutdown response with limited retry count
// - crowbar: high off, low on until restart
// - restart automatically 10 ms after fault, once over-voltage clears
// - external sync forces plain shutdown response
// - host rewrites over-voltage limit and response
// - under-voltage below nominal minus 15 percent
// - power-good bit only in tolerance, no fault
// - power-good pin open-drain or push-pull
// - power-good hysteresis 90 and 85 percent
// - power-good delay, 10 ms default
// - autotune variant: power good after tuning
// - switching 320 kHz, range 200 to 640
// - internal clock default, sync in or out
// - phase offset, sixteen positions, when synced
// - start autotune after ramp-up completes
`timescale 1ns/1ps
`default_nettype none
module output_setpoint_supervisor
   import setpoint_supervisor_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P     = MS_CYCLES,
   parameter bit          AUTOTUNE_VARIANT = 1'b1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        strap_res_present_i,
   input  wire logic [4:0]  strap_res_idx_i,
   input  wire logic        strap_short_i,
   input  wire logic        strap_high_i,
   input  wire logic        enable_i,
   input  wire logic        sync_i,
   input  wire logic [15:0] vout_mv_i,
   input  wire logic        autotune_done_i,
   output logic      [15:0] setpoint_mv_o,
   output logic             high_side_en_o,
   output logic             low_side_en_o,
   output logic             sw_pulse_o,
   output logic             sync_o,
   output logic             sync_oe_o,
   output logic             power_good_o,
   output logic             power_good_oe_o,
   output logic             autotune_start_o
);

   function automatic logic [15:0] bin_ceiling(input logic [15:0] mv);
      logic [15:0] c;
      c = BIN_CEIL[5];
      for (int i = 4; i >= 0; i--) begin
         if (mv < BIN_EDGE[i]) begin
            c = BIN_CEIL[i];
         end
      end
      return c;
   endfunction : bin_ceiling

   function automatic logic [25:0] scale(input logic [15:0] mv,
                                         input logic [8:0]  pct);
      return {10'h000, mv} * {17'h00000, pct};
   endfunction : scale

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // two-stage synchronisers for pins
   localparam int unsigned NPIN = 10;
   logic [NPIN-1:0] pin_meta_q;
   logic [NPIN-1:0] pin_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_q <= '0;
         pin_q      <= '0;
      end else begin
         pin_meta_q <= {strap_res_present_i, strap_res_idx_i, strap_short_i,
                        strap_high_i, enable_i, sync_i};
         pin_q      <= pin_meta_q;
      end
   end

   logic       res_present_s;
   logic [4:0] res_idx_s;
   logic       short_s;
   logic       high_s;
   logic       enable_s;
   logic       sync_s;
   assign {res_present_s, res_idx_s, short_s, high_s, enable_s, sync_s} =
          pin_q;

   cfg_t        cfg_q;
   state_t      state_q;
   logic [15:0] nominal_q;
   logic [15:0] max_q;
   logic [15:0] ceil_q;
   logic [15:0] target_q;
   logic [2:0]  settle_q;
   logic [3:0]  retries_q;
   logic [15:0] fault_ms_q;
   logic [15:0] ms_cnt_q;
   logic        ms_tick_q;
   logic        ov_flag_q;
   logic        uv_flag_q;
   logic        pg_cond_q;
   logic        pg_q;
   logic [15:0] pg_ms_q;
   logic        ramp_done_q;
   logic        tune_done_q;
   logic        tune_start_q;
   logic [15:0] acc_q;
   logic        sync_prev_q;
   logic        sw_pulse_q;
   logic        hs_q;
   logic        ls_q;
   logic        pgo_q;
   logic        pgoe_q;
   logic        synco_q;
   logic        syncoe_q;
   logic        ack_q;
   logic [31:0] rdata_q;

   logic        running;
   assign running = (state_q == S_RUN);

   // strap decode
   logic [15:0] strap_nom;
   logic [15:0] strap_max;
   logic [19:0] nom_x11;
   always_comb begin
      strap_nom = FLOAT_MV;
      nom_x11   = '0;
      if (res_present_s) begin
         if (res_idx_s < 5'(STRAP_LEVELS)) begin
            strap_nom = STRAP_MV[res_idx_s];
         end else begin
            strap_nom = STRAP_MV[STRAP_LEVELS-1];
         end
         nom_x11   = {4'h0, strap_nom} * {16'h0000, MAX_NUM};
         strap_max = 16'(nom_x11 / MAX_DEN);
      end else begin
         if (short_s) begin
            strap_nom = SHORT_MV;
         end else if (high_s) begin
            strap_nom = HIGH_MV;
         end
         strap_max = strap_nom;
      end
   end

   // setpoint selection and limits
   logic [15:0] req_mv;
   logic [15:0] lim_mv;
   logic [15:0] target_d;
   always_comb begin
      req_mv = cfg_q.ovr_en ? cfg_q.cmd_mv : nominal_q;
      lim_mv = max_q;
      if (state_q != S_OFF && state_q != S_INIT && ceil_q < lim_mv) begin
         lim_mv = ceil_q;
      end
      target_d = (req_mv > lim_mv) ? lim_mv : req_mv;
   end

   // thresholds in mV times percent
   logic [25:0] vout_x100;
   logic [25:0] ov_lim;
   logic [25:0] uv_lim;
   logic [25:0] pgon_lim;
   logic [25:0] pgoff_lim;
   logic        ov_now;
   logic        uv_now;
   always_comb begin
      vout_x100 = scale(vout_mv_i, PCT_FULL);
      ov_lim    = scale(target_q, PCT_FULL + {1'b0, cfg_q.ov_pct});
      uv_lim    = (cfg_q.uv_pct >= PCT_FULL[7:0]) ? '0 :
                  scale(target_q, PCT_FULL - {1'b0, cfg_q.uv_pct});
      pgon_lim  = scale(target_q, {1'b0, cfg_q.pg_on});
      pgoff_lim = scale(target_q, {1'b0, cfg_q.pg_off});
      ov_now    = (state_q != S_INIT) && (vout_x100 > ov_lim);
      uv_now    = running && ramp_done_q && (vout_x100 < uv_lim);
   end

   // millisecond tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_cnt_q  <= '0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == 16'(MS_CYCLES_P - 1)) begin
         ms_cnt_q  <= '0;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q  <= ms_cnt_q + 16'h0001;
         ms_tick_q <= 1'b0;
      end
   end

   // main sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q    <= S_INIT;
         settle_q   <= '0;
         nominal_q  <= '0;
         max_q      <= '0;
         ceil_q     <= '0;
         retries_q  <= '0;
         fault_ms_q <= '0;
      end else begin
         case (state_q)
            S_INIT: begin
               settle_q <= settle_q + 3'h1;
               if (settle_q == 3'(STRAP_SETTLE)) begin
                  nominal_q <= strap_nom;
                  max_q     <= strap_max;
                  state_q   <= S_OFF;
               end
            end
            S_OFF: begin
               if (enable_s) begin
                  ceil_q    <= bin_ceiling(target_q);
                  retries_q <= cfg_q.retry;
                  state_q   <= S_RUN;
               end
            end
            S_RUN: begin
               fault_ms_q <= '0;
               if (!enable_s) begin
                  state_q <= S_OFF;
               end else if (ov_now) begin
                  state_q <= S_FAULT;
               end
            end
            S_FAULT: begin
               if (ms_tick_q && fault_ms_q != 16'(RESTART_MS)) begin
                  fault_ms_q <= fault_ms_q + 16'h0001;
               end
               if (!enable_s) begin
                  state_q <= S_OFF;
               end else if (fault_ms_q == 16'(RESTART_MS) && !ov_now) begin
                  fault_ms_q <= '0;
                  if (retries_q == RETRY_INF) begin
                     state_q <= S_RUN;
                  end else if (retries_q != 4'h0) begin
                     retries_q <= retries_q - 4'h1;
                     state_q   <= S_RUN;
                  end else begin
                     state_q <= S_LOCK;
                  end
               end
            end
            S_LOCK: begin
               if (!enable_s) begin
                  state_q <= S_OFF;
               end
            end
            default: begin
               state_q <= S_INIT;
            end
         endcase
      end
   end

   // applied setpoint
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         target_q <= '0;
      end else begin
         target_q <= target_d;
      end
   end

   // gate drive permission
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hs_q <= 1'b0;
         ls_q <= 1'b0;
      end else begin
         hs_q <= running;
         ls_q <= running ||
                 ((state_q == S_FAULT || state_q == S_LOCK) &&
                  cfg_q.crowbar && cfg_q.sync_mode != SYNC_INPUT);
      end
   end

   // ramp detection and autotune
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ramp_done_q  <= 1'b0;
         tune_done_q  <= 1'b0;
         tune_start_q <= 1'b0;
      end else begin
         tune_start_q <= 1'b0;
         if (!running) begin
            ramp_done_q <= 1'b0;
         end else if (!ramp_done_q && vout_x100 >= pgon_lim) begin
            ramp_done_q  <= 1'b1;
            tune_start_q <= cfg_q.tune_en;
         end
         if (state_q == S_OFF) begin
            tune_done_q <= 1'b0;
         end else if (running && autotune_done_i) begin
            tune_done_q <= 1'b1;
         end
      end
   end

   // power good
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pg_cond_q <= 1'b0;
         pg_q      <= 1'b0;
         pg_ms_q   <= '0;
      end else begin
         if (!running || ov_now || uv_now) begin
            pg_cond_q <= 1'b0;
         end else if (vout_x100 >= pgon_lim) begin
            pg_cond_q <= 1'b1;
         end else if (vout_x100 < pgoff_lim) begin
            pg_cond_q <= 1'b0;
         end
         if (!pg_cond_q) begin
            pg_q    <= 1'b0;
            pg_ms_q <= '0;
         end else if (cfg_q.pg_tune && cfg_q.tune_en) begin
            pg_q <= tune_done_q;
         end else if (pg_ms_q >= cfg_q.pg_dly) begin
            pg_q <= 1'b1;
         end else if (ms_tick_q) begin
            pg_ms_q <= pg_ms_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pgo_q  <= 1'b0;
         pgoe_q <= 1'b0;
      end else begin
         pgo_q  <= cfg_q.pg_pp ? pg_q : 1'b0;
         pgoe_q <= cfg_q.pg_pp ? 1'b1 : !pg_q;
      end
   end

   // switching clock and sync
   logic [16:0] acc_sum;
   logic        sync_rise;
   assign acc_sum   = {1'b0, acc_q} + {7'h00, cfg_q.fsw};
   assign sync_rise = sync_s && !sync_prev_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q       <= '0;
         sync_prev_q <= 1'b0;
         sw_pulse_q  <= 1'b0;
         synco_q     <= 1'b0;
         syncoe_q    <= 1'b0;
      end else begin
         sync_prev_q <= sync_s;
         sw_pulse_q  <= 1'b0;
         // sync pin only in input mode
         if (cfg_q.sync_mode == SYNC_INPUT && sync_rise) begin
            acc_q <= 16'({12'h000, cfg_q.phase} * 16'(CLK_KHZ / PHASES));
         end else if (acc_sum >= 17'(CLK_KHZ)) begin
            acc_q      <= 16'(acc_sum - 17'(CLK_KHZ));
            sw_pulse_q <= running;
         end else begin
            acc_q <= acc_sum[15:0];
         end
         syncoe_q <= (cfg_q.sync_mode == SYNC_OUTPUT);
         synco_q  <= (cfg_q.sync_mode == SYNC_OUTPUT) &&
                     (acc_sum >= 17'(CLK_KHZ));
      end
   end

   // wishbone slave
   logic        req;
   logic [31:0] rd_word;
   logic [31:0] wr_word;
   assign req     = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_word = merge(rd_word, wb_dat_i, wb_sel_i);
   always_comb begin
      rd_word = '0;
      if (wb_adr_i == ADDR_CTRL) begin
         rd_word[15:0] = {cfg_q.retry, cfg_q.phase, 1'b0, cfg_q.crowbar,
                          cfg_q.sync_mode, cfg_q.tune_en, cfg_q.pg_tune,
                          cfg_q.pg_pp, cfg_q.ovr_en};
      end else if (wb_adr_i == ADDR_SETPT) begin
         rd_word[15:0] = cfg_q.cmd_mv;
      end else if (wb_adr_i == ADDR_OVUV) begin
         rd_word[15:0] = {cfg_q.uv_pct, cfg_q.ov_pct};
      end else if (wb_adr_i == ADDR_PGTH) begin
         rd_word[15:0] = {cfg_q.pg_off, cfg_q.pg_on};
      end else if (wb_adr_i == ADDR_PGDLY) begin
         rd_word[15:0] = cfg_q.pg_dly;
      end else if (wb_adr_i == ADDR_FSW) begin
         rd_word[9:0] = cfg_q.fsw;
      end else if (wb_adr_i == ADDR_STATUS) begin
         rd_word = {nominal_q, 10'h000, tune_done_q, running,
                    state_q == S_LOCK, uv_flag_q, ov_flag_q, pg_q};
      end else if (wb_adr_i == ADDR_LIMITS) begin
         rd_word = {max_q, target_q};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q   <= req;
         rdata_q <= req ? rd_word : '0;
      end
   end

   // configuration registers
   logic [9:0] fsw_w;
   assign fsw_w = wr_word[9:0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_q           <= '0;
         cfg_q.retry     <= RETRY_RST;
         cfg_q.crowbar   <= 1'b1;
         cfg_q.sync_mode <= SYNC_INTERNAL;
         cfg_q.tune_en   <= AUTOTUNE_VARIANT;
         cfg_q.pg_tune   <= AUTOTUNE_VARIANT;
         cfg_q.ov_pct    <= OV_PCT_RST;
         cfg_q.uv_pct    <= UV_PCT_RST;
         cfg_q.pg_on     <= PG_ON_RST;
         cfg_q.pg_off    <= PG_OFF_RST;
         cfg_q.pg_dly    <= PG_DLY_RST;
         cfg_q.fsw       <= FSW_RST;
      end else if (req && wb_we_i) begin
         if (wb_adr_i == ADDR_CTRL) begin
            {cfg_q.retry, cfg_q.phase} <= wr_word[15:8];
            cfg_q.crowbar   <= wr_word[6];
            cfg_q.sync_mode <= sync_mode_t'(wr_word[5:4]);
            cfg_q.tune_en   <= wr_word[3];
            cfg_q.pg_tune   <= wr_word[2];
            cfg_q.pg_pp     <= wr_word[1];
            cfg_q.ovr_en    <= wr_word[0];
         end else if (wb_adr_i == ADDR_SETPT) begin
            cfg_q.cmd_mv <= wr_word[15:0];
         end else if (wb_adr_i == ADDR_OVUV) begin
            {cfg_q.uv_pct, cfg_q.ov_pct} <= wr_word[15:0];
         end else if (wb_adr_i == ADDR_PGTH) begin
            {cfg_q.pg_off, cfg_q.pg_on} <= wr_word[15:0];
         end else if (wb_adr_i == ADDR_PGDLY) begin
            cfg_q.pg_dly <= wr_word[15:0];
         end else if (wb_adr_i == ADDR_FSW) begin
            cfg_q.fsw <= (fsw_w < FSW_MIN) ? FSW_MIN :
                         (fsw_w > FSW_MAX) ? FSW_MAX : fsw_w;
         end
      end
   end

   // sticky fault flags, set wins over clear
   logic st_clr;
   assign st_clr = req && wb_we_i && (wb_adr_i == ADDR_STATUS) && wb_sel_i[0];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ov_flag_q <= 1'b0;
         uv_flag_q <= 1'b0;
      end else begin
         ov_flag_q <= ov_now ||
                      (ov_flag_q && !(st_clr && wb_dat_i[ST_OV_BIT]));
         uv_flag_q <= uv_now ||
                      (uv_flag_q && !(st_clr && wb_dat_i[ST_UV_BIT]));
      end
   end

   assign wb_dat_o         = rdata_q;
   assign wb_ack_o         = ack_q;
   assign setpoint_mv_o    = target_q;
   assign high_side_en_o   = hs_q;
   assign low_side_en_o    = ls_q;
   assign sw_pulse_o       = sw_pulse_q;
   assign sync_o           = synco_q;
   assign sync_oe_o        = syncoe_q;
   assign power_good_o     = pgo_q;
   assign power_good_oe_o  = pgoe_q;
   assign autotune_start_o = tune_start_q;

endmodule : output_setpoint_supervisor
`default_nettype wire

// ### testbench/sup_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sup_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [15:0] vout_mv_i,
   input wire logic [15:0] setpoint_mv_o,
   input wire logic        high_side_en_o,
   input wire logic        sw_pulse_o,
   input wire logic        sync_o,
   input wire logic        sync_oe_o,
   input wire logic        power_good_o,
   input wire logic        power_good_oe_o,
   input wire logic        autotune_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("no bus ack");
   property p_ack1;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack1: assert property (p_ack1) else $error("ack too long");
   property p_max;
      setpoint_mv_o <= 16'h0e2e;
   endproperty
   a_max: assert property (p_max) else $error("setpoint over max");
   property p_ov;
      high_side_en_o && (32'(vout_mv_i) * 100 > 32'(setpoint_mv_o) * 115)
         |-> ##[1:3] !high_side_en_o;
   endproperty
   a_ov: assert property (p_ov) else $error("no ov shutdown");
   property p_pg;
      power_good_o |-> power_good_oe_o;
   endproperty
   a_pg: assert property (p_pg) else $error("pg pin drive");
   property p_tune;
      autotune_start_o |=> !autotune_start_o;
   endproperty
   a_tune: assert property (p_tune) else $error("tune pulse");
   property p_sw;
      sw_pulse_o |=> !sw_pulse_o;
   endproperty
   a_sw: assert property (p_sw) else $error("switch pulse");
   property p_sync;
      sync_o |-> sync_oe_o;
   endproperty
   a_sync: assert property (p_sync) else $error("sync drive");
   c_ack: cover property (wb_ack_o);
   c_rst: cover property (!high_side_en_o ##1 high_side_en_o);
   c_pg: cover property (power_good_o);
endmodule : sup_checker
bind output_setpoint_supervisor sup_checker chk (.*);
`default_nettype wire

// ### testbench/sync_neighbour.sv
`timescale 1ns/1ps
`default_nettype none
module sync_neighbour (
   input  wire logic clk_i,
   output var logic  sync_o
);
   logic [6:0] cnt_q = 7'h00;
   always_ff @(posedge clk_i) begin
      cnt_q  <= (cnt_q == 7'h4d) ? 7'h00 : cnt_q + 7'h01;
      sync_o <= (cnt_q == 7'h00);
   end
endmodule : sync_neighbour
`default_nettype wire

// ### testbench/output_setpoint_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module output_setpoint_supervisor_tb_top;
   import setpoint_supervisor_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, en = 0;
   logic pres = 0, sh = 0, hi = 1, ack, hs, ls, pg, pgoe, sync_i, sw, soe;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wd = 32'h0, rd_o, r;
   logic [4:0]  idx = 5'h1b;
   logic [15:0] vout = 16'h0, sp;
   int errors = 0, n_checks = 0;
   always #20 clk_i = ~clk_i;
   output_setpoint_supervisor #(.MS_CYCLES_P(10), .AUTOTUNE_VARIANT(1'b0))
   DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd),
      .wb_dat_o(rd_o), .wb_ack_o(ack), .strap_res_present_i(pres),
      .strap_res_idx_i(idx), .strap_short_i(sh), .strap_high_i(hi),
      .enable_i(en), .sync_i(sync_i), .vout_mv_i(vout),
      .autotune_done_i(1'b0), .setpoint_mv_o(sp), .high_side_en_o(hs),
      .low_side_en_o(ls), .sw_pulse_o(sw), .sync_o(), .sync_oe_o(soe),
      .power_good_o(pg), .power_good_oe_o(pgoe), .autotune_start_o());
   sync_neighbour nb (.clk_i(clk_i), .sync_o(sync_i));
   task finish_test;
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task cyc_n(input int c);
      repeat (c) @(posedge clk_i);
   endtask : cyc_n
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) errors++;
      r = rd_o;
      cyc <= 0; stb <= 0; we <= 0;
   endtask : wb
   task do_rst;
      rst_i <= 1; cyc_n(3); rst_i <= 0; cyc_n(10);
   endtask : do_rst
   task t_strap;
      do_rst(); wb(0, ADDR_STATUS, 0);
      chk(r[31:16], HIGH_MV);
      pres <= 1; do_rst(); wb(0, ADDR_STATUS, 0);
      chk(r[31:16], STRAP_MV[27]);
      idx <= 5'h00; cyc_n(5); wb(0, ADDR_STATUS, 0);
      chk(r[31:16], 16'h0ce4);
   endtask : t_strap
   task t_limit;
      wb(1, ADDR_CTRL, 32'hf041); wb(1, ADDR_SETPT, 32'hffff); cyc_n(3);
      chk(sp, 16'h0e2e);
      wb(1, ADDR_SETPT, 32'h03e8); cyc_n(3);
      chk(sp, 16'h03e8);
      en <= 1; cyc_n(6); wb(1, ADDR_SETPT, 32'hffff); cyc_n(3);
      chk(sp, 16'h06a4);
   endtask : t_limit
   task t_pg;
      vout <= 16'h06a4; cyc_n(50);
      chk(pgoe, 1);
      cyc_n(80);
      chk(pgoe, 0);
      wb(0, ADDR_STATUS, 0);
      chk(r[0], 1);
      wb(1, ADDR_CTRL, 32'hf043); cyc_n(3);
      chk(pg, 1);
      vout <= 16'h05d8; cyc_n(5);
      chk(pg, 1);
      vout <= 16'h0594; cyc_n(5);
      chk(pg, 0);
      vout <= 16'h06a4;
   endtask : t_pg
   task t_ov;
      vout <= 16'h07f8; cyc_n(4);
      chk(hs, 0);
      chk(ls, 1);
      wb(0, ADDR_STATUS, 0);
      chk(r[1], 1);
      chk(r[2], 1);
      vout <= 16'h06a4; cyc_n(130);
      chk(hs, 1);
      wb(1, ADDR_OVUV, 32'h0f05); vout <= 16'h0730; cyc_n(4);
      chk(hs, 0);
      vout <= 16'h06a4;
   endtask : t_ov
   task t_sync;
      int n;
      n = 0;
      vout <= 16'h0730; cyc_n(4);
      wb(1, ADDR_CTRL, 32'hf051); cyc_n(3);
      chk(ls, 0);
      vout <= 16'h06a4; cyc_n(130);
      wb(1, ADDR_CTRL, 32'hf061); cyc_n(2);
      chk(soe, 1);
      wb(1, ADDR_FSW, 32'h03ff); wb(0, ADDR_FSW, 0);
      chk(r[9:0], FSW_MAX);
      repeat (391) begin
         @(posedge clk_i);
         n += sw;
      end
      chk(n inside {10, 11}, 1);
   endtask : t_sync
   initial begin
      t_strap(); t_limit(); t_pg(); t_ov(); t_sync();
      finish_test();
   end
   initial begin
      repeat (4000) @(posedge clk_i);
      errors++;
      finish_test();
   end
endmodule : output_setpoint_supervisor_tb_top
`default_nettype wire
